//--- include/smsfe_pkg.sv
// How it works
// R1: In asynchronous mode every bit on the data line lasts 372 clock periods.
// R2: In synchronous mode incoming data is sampled on the clock rising edge.
// R3: In synchronous mode outgoing data changes on the clock falling edge.
// R4: A reset sequence in async mode sends the eight reset-answer bytes.
// R5: No reset-answer sequence is ever sent in synchronous mode.
// R6: An unconnected reset pin reads high through an internal pull-up.
// R7: The data line is open drain: pulled low or released, never driven high.
// R8: Up to fifteen devices share the bus, each picked by its own address.
// R9: User memory is eight 128-byte zones, each with its own access rights.
// R10: Writes take one byte or a page of up to 16, then a self-timed cycle.
// R11: Eight password sets of two 24-bit passwords gate zone access.
// R12: Up to four key sets back authentication of the zones.
// R13: The synchronous bus runs at serial clock rates up to 1.0 MHz.
// R14: The host opens every command with a start condition.
// R15: The host changes data only while the clock is low, bar start and stop.
package smsfe_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 100;
  localparam int ETU_CLKS = 372;
  localparam int ATR_START_DELAY_CLKS = 400;
  localparam int ETU_W = $clog2(ATR_START_DELAY_CLKS);
  localparam int T_WR_MS = 5;
  localparam int TWR_CYCLES_DEF = T_WR_MS * 1000 * CLK_MHZ;
  localparam int SCL_MAX_KHZ = 1000;
  localparam int SCL_HALF_MIN_CLKS = CLK_MHZ * 1000 / (2 * SCL_MAX_KHZ);
  // Reset-answer framing
  localparam int ATR_BYTES = 8;
  localparam int ATR_FRAME_BITS = 12;
  // Memory organisation
  localparam int NUM_ZONES = 8;
  localparam int ZONE_BYTES = 128;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = NUM_ZONES * ZONE_BYTES;
  localparam int NUM_PW_SETS = 8;
  localparam int PW_BITS = 24;
  localparam int NUM_KEY_SETS = 4;
  // Bus addressing and commands
  localparam logic [3:0] ADDR_RESERVED = 4'hf;
  localparam logic [3:0] CMD_WRITE = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h1;
  localparam logic [3:0] CMD_VERIFY = 4'h3;
  // Zone config byte fields
  localparam int ZC_BITS = 8;
  localparam int ZC_PW_LSB = 0;
  localparam int ZC_NEED_PW = 4;
  localparam int ZC_KEY_LSB = 5;
  localparam int ZC_NEED_AUTH = 7;
  // Reset values
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum {B_IDLE, B_RX, B_ACK_WAIT, B_ACK, B_TX, B_TX_ACK} smsfe_bus_e;
  typedef enum {A_IDLE, A_DELAY, A_SEND, A_DONE} smsfe_atr_e;
endpackage

//--- include/smsfe_pin_if.sv
`timescale 1ns/1ps
// Synchronised pin levels and edge events
interface smsfe_pin_if;
  logic scl;
  logic sda;
  logic rst_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic rst_rise;
  modport src (output scl, sda, rst_lvl, scl_rise, scl_fall, start_ev,
    stop_ev, rst_rise);
  modport dst (input scl, sda, rst_lvl, scl_rise, scl_fall, start_ev,
    stop_ev, rst_rise);
endinterface

//--- logic/smsfe_pin_sync.sv
`timescale 1ns/1ps
module smsfe_pin_sync import smsfe_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic rst_pin_in,
  input wire logic rst_pin_en,
  smsfe_pin_if.src pins
);
  logic [2:0] raw;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;

  // Undriven reset pad floats to the pull-up level
  assign raw = {rst_pin_en ? rst_pin_in : LINE_IDLE, sda_pin, scl_pin}; // R6

  // Two-stage synchronisers plus one history stage for edges
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1_q[i] <= LINE_IDLE;
          s2_q[i] <= LINE_IDLE;
          s3_q[i] <= LINE_IDLE;
        end else begin
          s1_q[i] <= raw[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
        end
      end
    end
  endgenerate

  // 100 MHz sampling gives 50 samples per half period at 1 MHz
  assign pins.scl = s2_q[0]; // R13
  assign pins.sda = s2_q[1];
  assign pins.rst_lvl = s2_q[2];
  assign pins.scl_rise = s2_q[0] & ~s3_q[0];
  assign pins.scl_fall = ~s2_q[0] & s3_q[0];
  // Data moving with clock high marks start or stop
  assign pins.start_ev = s2_q[0] & s3_q[0] & ~s2_q[1] & s3_q[1]; // R14
  assign pins.stop_ev = s2_q[0] & s3_q[0] & s2_q[1] & ~s3_q[1]; // R15
  assign pins.rst_rise = s2_q[2] & ~s3_q[2];
endmodule

//--- logic/smsfe_top.sv
`timescale 1ns/1ps
module smsfe_top import smsfe_pkg::*; #(
  parameter int TWR_CYCLES = TWR_CYCLES_DEF
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic SCL_CLK,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic RST_PIN_IN,
  input wire logic RST_PIN_EN,
  input wire logic [3:0] DEV_ADDR,
  input wire logic [ATR_BYTES*8-1:0] ATR_VALUE,
  input wire logic [NUM_ZONES*ZC_BITS-1:0] ZONE_CFG,
  input wire logic [NUM_PW_SETS*2*PW_BITS-1:0] PASSWORDS,
  input wire logic [NUM_KEY_SETS-1:0] AUTH_OK,
  output logic MODE_ASYNC,
  output logic ATR_ACTIVE,
  output logic WRITE_BUSY
);
  localparam int BW = $clog2(TWR_CYCLES + 1);

  smsfe_pin_if pins ();

  smsfe_bus_e bus_st_q;
  smsfe_atr_e atr_st_q;
  logic mode_async_q;
  logic [ETU_W-1:0] etu_q;
  logic [3:0] abit_q;
  logic [2:0] abyte_q;
  logic [ATR_FRAME_BITS-1:0] frame_q;
  logic a_oe_q;
  logic [3:0] bcnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [2:0] idx_q;
  logic [3:0] cmd_q;
  logic [2:0] zone_q;
  logic [6:0] addr_q;
  logic ack_q;
  logic s_oe_q;
  logic [3:0] pw_sel_q;
  logic [15:0] pw_buf_q;
  logic [2*NUM_PW_SETS-1:0] pw_ok_q;
  logic [PAGE_BYTES-1:0] mask_q;
  logic [5:0] base_q;
  logic busy_q;
  logic [BW-1:0] busy_cnt_q;
  logic [7:0] page_q [PAGE_BYTES];
  logic [7:0] mem_q [MEM_BYTES];
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic byte_done;
  logic ack_ok;
  logic wr_byte;
  logic commit;

  // One reset-answer character: start, data LSB first, even parity, guard
  function automatic logic [ATR_FRAME_BITS-1:0] atr_char(
    input logic [ATR_BYTES*8-1:0] v,
    input logic [2:0] n
  );
    logic [2:0] sel;
    logic [7:0] b;
    sel = 3'(ATR_BYTES - 1) - n;
    b = v[{sel, 3'b000} +: 8];
    return {2'b11, ^b, b, 1'b0};
  endfunction

  // Zone rights from its config byte, verified passwords and key sets
  function automatic logic zone_ok(
    input logic [ZC_BITS-1:0] cfg,
    input logic [2*NUM_PW_SETS-1:0] pwok,
    input logic [NUM_KEY_SETS-1:0] auth,
    input logic wr
  );
    logic [2:0] set;
    logic pw_pass;
    logic key_pass;
    set = cfg[ZC_PW_LSB +: 3];
    pw_pass = pwok[{set, 1'b0}] | (~wr & pwok[{set, 1'b1}]); // R11
    key_pass = auth[cfg[ZC_KEY_LSB +: 2]]; // R12
    return (~cfg[ZC_NEED_PW] | pw_pass) & (~cfg[ZC_NEED_AUTH] | key_pass);
  endfunction

  smsfe_pin_sync u_pin_sync (
    .clk(MCLK),
    .rst_n(RSTN),
    .scl_pin(SCL_CLK),
    .sda_pin(SDA_IN),
    .rst_pin_in(RST_PIN_IN),
    .rst_pin_en(RST_PIN_EN),
    .pins(pins.src)
  );

  // Byte decode shared by the bit engine, page buffer and password check
  assign rx_byte = {sh_q[6:0], pins.sda};
  assign rd_byte = mem_q[{zone_q, addr_q}]; // R9
  assign byte_done = (bus_st_q == B_RX) && pins.scl_rise &&
    (bcnt_q == 4'h7);
  assign wr_byte = byte_done && ack_ok && (cmd_q == CMD_WRITE) &&
    (idx_q >= 3'h3);
  assign commit = busy_q && (busy_cnt_q == BW'(TWR_CYCLES - 1));

  // Acknowledge decision for the byte now completing
  always_comb begin
    case (idx_q)
      3'h0: ack_ok = (rx_byte[3:0] == DEV_ADDR) &&
        (DEV_ADDR != ADDR_RESERVED) && !busy_q && // R8
        (rx_byte[7:4] == CMD_WRITE || rx_byte[7:4] == CMD_READ ||
        rx_byte[7:4] == CMD_VERIFY);
      3'h1: ack_ok = 1'b1;
      3'h2: ack_ok = (cmd_q == CMD_VERIFY) ||
        zone_ok(ZONE_CFG[zone_q*ZC_BITS +: ZC_BITS], pw_ok_q, AUTH_OK,
        cmd_q == CMD_WRITE); // R9
      default: ack_ok = (cmd_q == CMD_WRITE) ||
        ((cmd_q == CMD_VERIFY) && (idx_q <= 3'h4));
    endcase
  end

  // Reset pad ever seen low means a card reader owns the reset line
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      mode_async_q <= 1'b0;
    end else if (!pins.rst_lvl) begin
      mode_async_q <= 1'b1;
    end
  end

  // Reset-answer sender; a low reset pad aborts it at any point
  always_ff @(posedge MCLK) begin
    if (!RSTN || !pins.rst_lvl) begin
      atr_st_q <= A_IDLE;
      etu_q <= '0;
      abit_q <= 4'h0;
      abyte_q <= 3'h0;
      frame_q <= '1;
      a_oe_q <= 1'b0;
    end else begin
      case (atr_st_q)
        A_IDLE: begin
          if (pins.rst_rise && mode_async_q) begin // R5
            atr_st_q <= A_DELAY;
            etu_q <= '0;
          end
        end
        A_DELAY: begin
          if (pins.scl_rise) begin
            if (etu_q == ETU_W'(ATR_START_DELAY_CLKS - 1)) begin
              frame_q <= atr_char(ATR_VALUE, 3'h0); // R4
              a_oe_q <= 1'b1;
              abit_q <= 4'h0;
              abyte_q <= 3'h0;
              etu_q <= '0;
              atr_st_q <= A_SEND;
            end else begin
              etu_q <= etu_q + 1'b1;
            end
          end
        end
        A_SEND: begin
          if (pins.scl_rise) begin
            if (etu_q == ETU_W'(ETU_CLKS - 1)) begin // R1
              etu_q <= '0;
              if (abit_q == 4'(ATR_FRAME_BITS - 1)) begin
                abit_q <= 4'h0;
                if (abyte_q == 3'(ATR_BYTES - 1)) begin
                  a_oe_q <= 1'b0;
                  atr_st_q <= A_DONE;
                end else begin
                  abyte_q <= abyte_q + 3'h1;
                  frame_q <= atr_char(ATR_VALUE, abyte_q + 3'h1); // R4
                  a_oe_q <= 1'b1;
                end
              end else begin
                abit_q <= abit_q + 4'h1;
                frame_q <= {1'b1, frame_q[ATR_FRAME_BITS-1:1]};
                a_oe_q <= ~frame_q[1]; // R7
              end
            end else begin
              etu_q <= etu_q + 1'b1;
            end
          end
        end
        A_DONE: atr_st_q <= A_DONE;
        default: atr_st_q <= A_IDLE;
      endcase
    end
  end

  // Two-wire bit engine; start and stop override any state
  always_ff @(posedge MCLK) begin
    if (!RSTN || mode_async_q) begin
      bus_st_q <= B_IDLE;
      bcnt_q <= 4'h0;
      sh_q <= BYTE_RST;
      tx_q <= BYTE_RST;
      idx_q <= 3'h0;
      cmd_q <= 4'h0;
      zone_q <= 3'h0;
      addr_q <= 7'h00;
      ack_q <= 1'b0;
      s_oe_q <= 1'b0;
    end else if (pins.start_ev) begin // R14
      bus_st_q <= B_RX;
      bcnt_q <= 4'h0;
      idx_q <= 3'h0;
      s_oe_q <= 1'b0;
    end else if (pins.stop_ev) begin
      bus_st_q <= B_IDLE;
      s_oe_q <= 1'b0;
    end else begin
      case (bus_st_q)
        B_RX: begin
          if (pins.scl_rise) begin // R2
            sh_q <= rx_byte;
            bcnt_q <= bcnt_q + 4'h1;
            if (bcnt_q == 4'h7) begin
              bus_st_q <= B_ACK_WAIT;
              ack_q <= ack_ok;
              case (idx_q)
                3'h0: cmd_q <= rx_byte[7:4];
                3'h1: zone_q <= rx_byte[2:0];
                3'h2: addr_q <= rx_byte[6:0];
                default: begin
                  if (cmd_q == CMD_WRITE) begin
                    addr_q[3:0] <= addr_q[3:0] + 4'h1; // R10
                  end
                end
              endcase
            end
          end
        end
        B_ACK_WAIT: begin
          if (pins.scl_fall) begin // R3
            s_oe_q <= ack_q;
            bus_st_q <= ack_q ? B_ACK : B_IDLE;
          end
        end
        B_ACK: begin
          if (pins.scl_fall) begin // R3
            bcnt_q <= 4'h0;
            if (cmd_q == CMD_READ && idx_q >= 3'h2) begin
              tx_q <= rd_byte;
              s_oe_q <= ~rd_byte[7]; // R7
              bus_st_q <= B_TX;
            end else begin
              s_oe_q <= 1'b0;
              bus_st_q <= B_RX;
              if (idx_q != 3'h7) begin
                idx_q <= idx_q + 3'h1;
              end
            end
          end
        end
        B_TX: begin
          if (pins.scl_rise) begin
            bcnt_q <= bcnt_q + 4'h1;
          end else if (pins.scl_fall) begin // R3
            if (bcnt_q == 4'h8) begin
              s_oe_q <= 1'b0;
              bus_st_q <= B_TX_ACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              s_oe_q <= ~tx_q[6]; // R7
            end
          end
        end
        B_TX_ACK: begin
          if (pins.scl_rise) begin // R2
            if (pins.sda) begin
              bus_st_q <= B_IDLE;
            end else begin
              addr_q <= addr_q + 7'h01;
              bus_st_q <= B_ACK;
            end
          end
        end
        default: bus_st_q <= B_IDLE;
      endcase
    end
  end

  // Page buffer and self-timed write cycle; bus is refused while busy
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      mask_q <= '0;
      base_q <= 6'h00;
      busy_q <= 1'b0;
      busy_cnt_q <= '0;
    end else if (busy_q) begin
      busy_cnt_q <= busy_cnt_q + 1'b1;
      if (commit) begin // R10
        busy_q <= 1'b0;
        mask_q <= '0;
      end
    end else if (pins.start_ev) begin
      mask_q <= '0;
    end else if (wr_byte) begin // R10
      page_q[addr_q[3:0]] <= rx_byte;
      mask_q[addr_q[3:0]] <= 1'b1;
    end else if (pins.stop_ev && (mask_q != '0)) begin
      busy_q <= 1'b1;
      busy_cnt_q <= '0;
      base_q <= {zone_q, addr_q[6:4]};
    end
  end

  // Nonvolatile array; the buffered bytes of the page land together at the end of the cycle
  always_ff @(posedge MCLK) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_q[i]) begin
          mem_q[{base_q, 4'(i)}] <= page_q[i]; // R9
        end
      end
    end
  end

  // Password check: selector byte, then three bytes MSB first
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      pw_sel_q <= 4'h0;
      pw_buf_q <= 16'h0000;
      pw_ok_q <= '0;
    end else if (byte_done && ack_ok && cmd_q == CMD_VERIFY) begin
      case (idx_q)
        3'h1: pw_sel_q <= rx_byte[3:0];
        3'h2, 3'h3: pw_buf_q <= {pw_buf_q[7:0], rx_byte};
        3'h4: pw_ok_q[pw_sel_q] <= ({pw_buf_q, rx_byte} ==
          PASSWORDS[pw_sel_q*PW_BITS +: PW_BITS]); // R11
        default: pw_sel_q <= pw_sel_q;
      endcase
    end
  end

  // Registered pins and status; data output only ever pulls low
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      MODE_ASYNC <= 1'b0;
      ATR_ACTIVE <= 1'b0;
      WRITE_BUSY <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0; // R7
      SDA_OE <= mode_async_q ? a_oe_q : s_oe_q; // R5
      MODE_ASYNC <= mode_async_q;
      ATR_ACTIVE <= (atr_st_q == A_DELAY) || (atr_st_q == A_SEND);
      WRITE_BUSY <= busy_q;
    end
  end
endmodule

//--- dv/smsfe_top_sva.sv
`timescale 1ns/1ps
module smsfe_sva_chk import smsfe_pkg::*; #(
  parameter int TWR_CYCLES = TWR_CYCLES_DEF
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic SCL_CLK,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic RST_PIN_IN,
  input wire logic RST_PIN_EN,
  input wire logic MODE_ASYNC,
  input wire logic ATR_ACTIVE,
  input wire logic WRITE_BUSY
);
  default clocking dcb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  wire logic pad_low = RST_PIN_EN && !RST_PIN_IN;
  int busy_n_q;
  // Busy length counter; resets so a stuck flag shows up as too long
  always_ff @(posedge MCLK) begin
    if (!RSTN || !WRITE_BUSY) begin
      busy_n_q <= 0;
    end else begin
      busy_n_q <= busy_n_q + 1;
    end
  end
  property p_od; SDA_OUT == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data driven high");
  property p_nosync; !MODE_ASYNC |-> !ATR_ACTIVE; endproperty
  a_nosync: assert property (p_nosync) else $error("answer in sync");
  property p_pad;
    $rose(MODE_ASYNC) |->
      $past(pad_low, 3) || $past(pad_low, 4) || $past(pad_low, 5);
  endproperty
  a_pad: assert property (p_pad) else $error("async without pad low");
  property p_dly; $rose(ATR_ACTIVE) |-> !SDA_OE [*8]; endproperty
  a_dly: assert property (p_dly) else $error("no answer delay");
  property p_etu;
    $rose(SDA_OE) && ATR_ACTIVE |=> (SDA_OE || !ATR_ACTIVE) [*8];
  endproperty
  a_etu: assert property (p_etu) else $error("bit too short");
  property p_twr;
    $fell(WRITE_BUSY) |->
      busy_n_q >= TWR_CYCLES && busy_n_q <= TWR_CYCLES + 2;
  endproperty
  a_twr: assert property (p_twr) else $error("write time wrong");
  property p_fall;
    !MODE_ASYNC && $changed(SDA_OE) |-> !SCL_CLK && !$past(SCL_CLK, 3);
  endproperty
  a_fall: assert property (p_fall) else $error("data not on fall");
  property p_bsy; WRITE_BUSY && $past(WRITE_BUSY) |-> !$rose(SDA_OE);
  endproperty
  a_bsy: assert property (p_bsy) else $error("ack while busy");
endmodule

bind smsfe_top smsfe_sva_chk #(.TWR_CYCLES(TWR_CYCLES)) u_chk (
  .MCLK(MCLK),
  .RSTN(RSTN),
  .SCL_CLK(SCL_CLK),
  .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE),
  .RST_PIN_IN(RST_PIN_IN),
  .RST_PIN_EN(RST_PIN_EN),
  .MODE_ASYNC(MODE_ASYNC),
  .ATR_ACTIVE(ATR_ACTIVE),
  .WRITE_BUSY(WRITE_BUSY)
);

//--- dv/smsfe_host_model.sv
`timescale 1ns/1ps
module smsfe_host_model (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low,
  output logic rst_in,
  output logic rst_en
);
  // Idle bus; pad unbonded yet low inside, the pull-up must win
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rst_in = 1'b0;
    rst_en = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Half periods of 50 cycles: 1 MHz, the top rate
  task automatic bit_clk(input logic b, output logic s);
    tick(10);
    sda_low = !b;
    tick(40);
    scl = 1'b1;
    tick(25);
    s = sda_wire;
    tick(25);
    scl = 1'b0;
  endtask
  task automatic start();
    sda_low = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(30);
    sda_low = 1'b1;
    tick(30);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(10);
    sda_low = 1'b1;
    tick(10);
    scl = 1'b1;
    tick(30);
    sda_low = 1'b0;
    tick(30);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_clk(d[i], s);
    end
    bit_clk(1'b1, s);
    ack = !s;
  endtask
  // Host ack only when more bytes are wanted
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_clk(1'b1, s);
      d[i] = s;
    end
    bit_clk(!more, s);
  endtask
  // One carrier period of 160 ns
  task automatic carrier();
    #80;
    scl = 1'b1;
    #80;
    scl = 1'b0;
  endtask
  task automatic pad(input logic en, input logic v);
    tick(1);
    rst_en = en;
    rst_in = v;
  endtask
endmodule

//--- dv/test_secure_memory_serial_front_end.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module test_secure_memory_serial_front_end
  import smsfe_pkg::*;
;
  localparam int TWR = 2000;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] auth = 4'h0;
  logic [3:0] dev_addr = 4'h5;
  logic [ATR_BYTES*8-1:0] atr_val = 64'h3a11_2233_4455_6677;
  // Zone 1 needs key set 2, zone 3 needs password set 2
  logic [NUM_ZONES*ZC_BITS-1:0] zone_cfg = 64'h0000_0000_1200_c000;
  logic [NUM_PW_SETS*2*PW_BITS-1:0] pw;
  logic scl, sda_low, rst_in, rst_en;
  logic sda_out, sda_oe, mode_async, atr_active, busy;
  wire logic sda_wire = !(sda_oe || sda_low);
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 mclk = !mclk;

  smsfe_top #(.TWR_CYCLES(TWR)) u_dut (
    .MCLK(mclk), .RSTN(rstn), .SCL_CLK(scl), .SDA_IN(sda_wire),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .RST_PIN_IN(rst_in),
    .RST_PIN_EN(rst_en), .DEV_ADDR(dev_addr), .ATR_VALUE(atr_val),
    .ZONE_CFG(zone_cfg), .PASSWORDS(pw),
    .AUTH_OK(auth), .MODE_ASYNC(mode_async),
    .ATR_ACTIVE(atr_active), .WRITE_BUSY(busy)
  );
  smsfe_host_model u_host (.clk(mclk), .sda_wire(sda_wire), .scl(scl),
    .sda_low(sda_low), .rst_in(rst_in), .rst_en(rst_en));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 70k cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      give_verdict();
    end
  end
  // Command, zone and address bytes; acks MSB first
  task automatic hdr(input logic [7:0] b0, input logic [7:0] z,
      input logic [7:0] a, output logic [2:0] ak);
    u_host.start();
    u_host.wbyte(b0, ak[2]);
    u_host.wbyte(z, ak[1]);
    u_host.wbyte(a, ak[0]);
  endtask
  task automatic rd1(input logic [7:0] z, input logic [7:0] a,
      input logic [7:0] e);
    logic [2:0] ak;
    logic [7:0] d;
    hdr({CMD_READ, 4'h5}, z, a, ak);
    u_host.rbyte(1'b0, d);
    u_host.stop();
    `CHK(ak, 3'b111)
    `CHK(d, e)
  endtask
  // Wait out the self-timed write cycle, bounded
  task automatic wait_idle();
    for (int i = 0; i < TWR + 50 && busy !== 1'b0; i++) begin
      u_host.tick(1);
    end
    `CHK(busy, 1'b0)
  endtask
  // Page write across the page end, refused while busy, read back
  task automatic t_write();
    logic [2:0] ak;
    logic k0, k1, k2;
    hdr({CMD_WRITE, 4'h5}, 8'h00, 8'h0f, ak);
    u_host.wbyte(8'ha5, k0);
    u_host.wbyte(8'h3c, k1);
    u_host.stop();
    `CHK({ak, k0, k1}, 5'h1f)
    u_host.tick(20);
    `CHK(busy, 1'b1)
    u_host.start();
    u_host.wbyte({CMD_READ, 4'h5}, k2);
    u_host.stop();
    `CHK(k2, 1'b0)
    wait_idle();
    rd1(8'h00, 8'h0f, 8'ha5);
    rd1(8'h00, 8'h00, 8'h3c);
    $display("t_write done");
  endtask
  // Other device, unknown command, reserved own address; then a new one
  task automatic t_refuse();
    logic [7:0] b0 [3] = '{8'h16, 8'h75, 8'h1f};
    logic k;
    foreach (b0[i]) begin
      if (i == 2) dev_addr = 4'hf;
      u_host.start();
      u_host.wbyte(b0[i], k);
      u_host.stop();
      `CHK(k, 1'b0)
    end
    dev_addr = 4'he;
    u_host.start();
    u_host.wbyte({CMD_READ, 4'he}, k);
    u_host.stop();
    `CHK(k, 1'b1)
    dev_addr = 4'h5;
    $display("t_refuse done");
  endtask
  // Key set gates zone 1, config byte gates zone 0; write then read back
  task automatic t_auth();
    logic [2:0] ak;
    logic k;
    hdr({CMD_READ, 4'h5}, 8'h01, 8'h00, ak);
    u_host.stop();
    `CHK(ak, 3'b110)
    zone_cfg[7:0] = 8'h80;
    hdr({CMD_READ, 4'h5}, 8'h00, 8'h00, ak);
    u_host.stop();
    zone_cfg[7:0] = 8'h00;
    `CHK(ak, 3'b110)
    auth = 4'b0100;
    hdr({CMD_WRITE, 4'h5}, 8'h01, 8'h00, ak);
    u_host.wbyte(8'h5a, k);
    u_host.stop();
    `CHK({ak, k}, 4'hf)
    wait_idle();
    rd1(8'h01, 8'h00, 8'h5a);
    $display("t_auth done");
  endtask
  // Read password opens reads only, never writes
  task automatic t_pw();
    logic [2:0] ak;
    logic [4:0] k;
    logic [7:0] d;
    hdr({CMD_READ, 4'h5}, 8'h03, 8'h00, ak);
    u_host.stop();
    `CHK(ak, 3'b110)
    u_host.start();
    u_host.wbyte({CMD_VERIFY, 4'h5}, k[4]);
    u_host.wbyte(8'h05, k[3]);
    u_host.wbyte(8'hab, k[2]);
    u_host.wbyte(8'hcd, k[1]);
    u_host.wbyte(8'hef, k[0]);
    u_host.stop();
    `CHK(k, 5'h1f)
    hdr({CMD_READ, 4'h5}, 8'h03, 8'h00, ak);
    u_host.rbyte(1'b0, d);
    u_host.stop();
    `CHK(ak, 3'b111)
    hdr({CMD_WRITE, 4'h5}, 8'h03, 8'h00, ak);
    u_host.stop();
    `CHK(ak, 3'b110)
    u_host.tick(20);
    `CHK(busy, 1'b0)
    $display("t_pw done");
  endtask
  // Answer start, first two bits, then abort by pad low
  task automatic t_async();
    `CHK({mode_async, atr_active}, 2'b00)
    u_host.pad(1'b1, 1'b0);
    u_host.tick(10);
    `CHK(mode_async, 1'b1)
    u_host.pad(1'b1, 1'b1);
    for (int i = 1; i <= 1330; i++) begin
      u_host.carrier();
      if (i == 200) `CHK({atr_active, sda_oe}, 2'b10)
      if (i == 586) `CHK(sda_oe, 1'b1)
      if (i == 958) `CHK(sda_oe, 1'b1)
    end
    `CHK(sda_oe, 1'b0)
    u_host.pad(1'b1, 1'b0);
    u_host.tick(8);
    `CHK({atr_active, sda_oe}, 2'b00)
    $display("t_async done");
  endtask

  initial begin
    pw = '0;
    pw[96+:24] = 24'h123456;
    pw[120+:24] = 24'habcdef;
    repeat (4) @(posedge mclk);
    #1;
    rstn = 1'b1;
    u_host.tick(6);
    t_write();
    t_refuse();
    t_auth();
    t_pw();
    t_async();
    give_verdict();
  end
endmodule
